// *** design/asct_top.sv ***
/*
 serial command port, conversion pacing and input mux select logic.
 assumes host is serial master keeping its own spacing and hold times;
 serial clock is its own domain (mode 0: sample rising, shift falling).
*/
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE1 - host waits 50 oscillator periods before readout
// RULE2 - data out released 6-10 periods, instantly on deselect; code releases on deselect about 3 clk later, through the cs_n synchroniser
// RULE3 - host holds select 8 periods after write
// RULE4 - host spaces commands 4 oscillator periods
// RULE5 - host waits 2 conversions after calibration
// RULE6 - full cal 4 conversions, reset 16 periods
// RULE7 - input change within 5000 periods of start
// RULE8 - result register invalid 4 periods during update
// RULE9 - continuous mode first clock 10 periods after ready
// RULE10 - port works with select tied low
// RULE11 - any channel positive, any other negative
// RULE12 - eight or four channel variant supported
// RULE13 - analog common selectable as a channel
// RULE14 - first conversion after mux change valid
// RULE15 - host changes mux right after ready falls
// RULE16 - ready output driven low on new data
// RULE17 - low reset pin resets whole device; code resets system domain only, serial clock shifters keep their state
// RULE18 - ready pulled low when calibration completes
// RULE19 - host counts periods from known oscillator
module asct_top import asct_pkg::*; #(
	parameter int CONV_PERIOD_CYC = CONV_PERIOD_CYC_DEF,
	parameter bit LARGE_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic reset_pin_n,
	input wire logic [RESULT_W-1:0] modulator_result,
	output logic dout,
	output logic dout_oe,
	output logic conversion_ready_n,
	output asct_mux_s mux_sel
);
	// ==========================================
	// serial clock domain: shift in bytes, shift out result
	logic [2:0] bit_cnt;
	logic [6:0] sh_in;
	logic [7:0] rx_byte;
	logic rx_tog;
	logic [RESULT_W-1:0] sh_out;
	logic [RESULT_W-1:0] tx_word;
	logic rd_armed;

	// cs_n high clears the bit counter; tied low keeps framing by count alone
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt <= 3'h0; // RULE10
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// toggle is not cleared on deselect, else a false byte event would follow
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			sh_in <= 7'h00;
			rx_byte <= 8'h00;
			rx_tog <= 1'b0;
			rd_armed <= 1'b0;
		end else if (!cs_n) begin
			sh_in <= {sh_in[5:0], din};
			rd_armed <= 1'b0;
			if (bit_cnt == 3'h7) begin
				rx_byte <= {sh_in, din};
				rx_tog <= ~rx_tog;
				rd_armed <= {sh_in, din} == CMD_READ_RESULT;
			end
		end
	end

	// tx_word only moves as ready falls, and the host reads after that
	always_ff @(negedge sclk or posedge reset) begin
		if (reset) begin
			sh_out <= '0;
		end else if (rd_armed) begin
			sh_out <= tx_word;
		end else begin
			sh_out <= {sh_out[RESULT_W-2:0], 1'b0};
		end
	end

	// ==========================================
	// system domain: synchronisers
	logic [2:0] rx_tog_sync;
	logic [1:0] cs_sync, sclk_sync, rst_pin_sync;
	logic sclk_prev;
	logic [7:0] rx_byte_sys;
	always_ff @(posedge clk) begin
		rx_tog_sync <= {rx_tog_sync[1:0], rx_tog};
		cs_sync <= {cs_sync[0], cs_n};
		sclk_sync <= {sclk_sync[0], sclk};
		rst_pin_sync <= {rst_pin_sync[0], reset_pin_n};
		sclk_prev <= sclk_sync[1];
	end
	wire logic byte_evt = rx_tog_sync[2] ^ rx_tog_sync[1];
	wire logic sclk_edge = sclk_sync[1] ^ sclk_prev;
	// rx_byte is stable long after the toggle, so sampling it on the event is safe
	always_ff @(posedge clk) begin
		if (byte_evt) begin
			rx_byte_sys <= rx_byte;
		end
	end
	wire logic dev_reset = reset | ~rst_pin_sync[1]; // RULE17

	// ==========================================
	// command decoding
	typedef enum logic [2:0] {
		ST_CMD = 3'b001,
		ST_ARG = 3'b010,
		ST_DATA = 3'b100
	} asct_state_e;
	asct_state_e state;
	logic [7:0] cmd_hold;
	logic got_byte;
	logic cont_mode;
	logic cmd_reset;
	logic cal_start;
	logic [2:0] cal_periods;

	function automatic logic is_cal(input logic [7:0] c);
		return c == CMD_SELF_OFFSET_CAL || c == CMD_SELF_GAIN_CAL ||
			c == CMD_SYS_OFFSET_CAL || c == CMD_SYS_GAIN_CAL || c == CMD_SELF_FULL_CAL;
	endfunction

	always_ff @(posedge clk) begin
		got_byte <= byte_evt;
	end

	function automatic logic [3:0] clamp_ch(input logic [3:0] ch);
		// smaller variant only has channels 0-3 plus common
		if (ch == CH_COMMON || LARGE_VARIANT || ch < 4'(NUM_CH_SMALL)) begin // RULE12 RULE13
			return ch;
		end
		return 4'(ch[1:0]);
	endfunction

	always_ff @(posedge clk) begin
		cal_start <= 1'b0;
		cmd_reset <= 1'b0;
		if (dev_reset) begin
			state <= ST_CMD;
			cmd_hold <= 8'h00;
			cont_mode <= 1'b0;
			mux_sel <= MUX_RESET;
			cal_periods <= 3'h0;
		end else if (got_byte) begin
			unique case (state)
				ST_CMD: begin
					cmd_hold <= rx_byte_sys;
					if (rx_byte_sys == CMD_READ_CONT) begin
						cont_mode <= 1'b1;
					end else if (rx_byte_sys == CMD_STOP_CONT) begin
						cont_mode <= 1'b0;
					end else if (rx_byte_sys == CMD_RESET) begin
						cmd_reset <= 1'b1;
					end else if (is_cal(rx_byte_sys)) begin
						cal_start <= 1'b1;
						cal_periods <= (rx_byte_sys == CMD_SELF_FULL_CAL) ?
							3'(FULL_CAL_CONV_PERIODS) : 3'(CAL_CONV_PERIODS);
					end
					if (rx_byte_sys[7:4] == CMD_REG_WRITE[7:4]) begin
						state <= ST_ARG;
					end
				end
				ST_ARG: begin
					state <= ST_DATA;
				end
				ST_DATA: begin
					state <= ST_CMD;
					if (cmd_hold[3:0] == REG_MUX) begin
						// equal pos/neg is allowed; it reads as a shorted input
						mux_sel <= {clamp_ch(rx_byte_sys[7:4]), clamp_ch(rx_byte_sys[3:0])}; // RULE11
					end
				end
				default: state <= ST_CMD;
			endcase
		end
	end

	// ==========================================
	// conversion pacing and ready output
	logic [$clog2(CONV_PERIOD_CYC)-1:0] conv_cnt;
	logic [$clog2(DOR_INVALID_CYC+1)-1:0] upd_cnt;
	logic [2:0] cal_left;
	logic mux_changed;
	asct_mux_s mux_prev;
	logic store;
	wire logic conv_done = conv_cnt == ($clog2(CONV_PERIOD_CYC))'(CONV_PERIOD_CYC - 1);

	always_ff @(posedge clk) begin
		mux_prev <= mux_sel;
		store <= 1'b0;
		if (dev_reset || cmd_reset || cal_start) begin
			conv_cnt <= '0;
			mux_changed <= 1'b0;
			cal_left <= cal_start ? cal_periods : 3'h0;
		end else begin
			// restarting the filter on a mux change gives single-cycle settling
			if (mux_prev != mux_sel) begin
				conv_cnt <= '0; // RULE14
			end else if (conv_done) begin
				conv_cnt <= '0;
			end else begin
				conv_cnt <= conv_cnt + 1'b1;
			end
			if (conv_done && cal_left != 3'h0) begin
				cal_left <= cal_left - 3'h1;
			end
			store <= conv_done && cal_left <= 3'h1;
		end
	end

	// ready falls after the result register settles; high while updating
	always_ff @(posedge clk) begin
		if (dev_reset) begin
			conversion_ready_n <= 1'b1;
			upd_cnt <= '0;
		end else if (store) begin
			conversion_ready_n <= 1'b1; // RULE8
			upd_cnt <= ($clog2(DOR_INVALID_CYC+1))'(DOR_INVALID_CYC);
		end else if (upd_cnt != '0) begin
			upd_cnt <= upd_cnt - 1'b1;
			if (upd_cnt == 1) begin
				conversion_ready_n <= 1'b0; // RULE16 RULE18
			end
		end else if (byte_evt && !cont_mode) begin
			conversion_ready_n <= 1'b1;
		end
	end

	logic [RESULT_W-1:0] mem_rdata;
	asct_result_mem u_mem (
		.clk(clk),
		.we(store),
		.waddr(mux_sel.pos[2:0]),
		.wdata(modulator_result),
		.raddr(mux_sel.pos[2:0]),
		.rdata(mem_rdata)
	);

	// word to the shifter is quasi-static: it changes only as ready falls
	always_ff @(posedge clk) begin
		if (dev_reset) begin
			tx_word <= '0;
		end else if (upd_cnt == 1) begin
			tx_word <= mem_rdata;
		end
	end

	// ==========================================
	// data out enable and release timing
	logic [$clog2(DOUT_RELEASE_CYC+1)-1:0] idle_cnt;
	always_ff @(posedge clk) begin
		if (dev_reset || cs_sync[1]) begin
			dout_oe <= 1'b0; // RULE2
			idle_cnt <= '0;
		end else if (sclk_edge) begin
			dout_oe <= 1'b1;
			idle_cnt <= ($clog2(DOUT_RELEASE_CYC+1))'(DOUT_RELEASE_CYC);
		end else if (idle_cnt != '0) begin
			idle_cnt <= idle_cnt - 1'b1;
			if (idle_cnt == 1) begin
				dout_oe <= 1'b0; // RULE2
			end
		end
	end

	always_ff @(posedge clk) begin
		if (dev_reset) begin
			dout <= 1'b0;
		end else begin
			dout <= sh_out[RESULT_W-1];
		end
	end
endmodule // asct_top
`default_nettype wire

// *** design/asct_pkg.sv ***
/*
 package for the serial command port of a multichannel converter:
 command codes, timing counts, mux channel codes and carrier structs.
 assumes a 100 MHz system clock; oscillator period is a parameter.
*/
package asct_pkg;
	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_PERIOD_NS = 400;
	localparam int OSC_CYC = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DOUT_RELEASE_MIN_OSC = 6;
	localparam int DOUT_RELEASE_MAX_OSC = 10;
	localparam int DOUT_RELEASE_OSC = 8;
	localparam int DOUT_RELEASE_CYC = DOUT_RELEASE_OSC * OSC_CYC;
	localparam int DOR_INVALID_OSC = 4;
	localparam int DOR_INVALID_CYC = DOR_INVALID_OSC * OSC_CYC;
	localparam int CONV_PERIOD_CYC_DEF = 20000;
	localparam int CAL_CONV_PERIODS = 2;
	localparam int FULL_CAL_CONV_PERIODS = 4;
	// ==========================================
	// commands
	localparam logic [7:0] CMD_READ_RESULT = 8'h01;
	localparam logic [7:0] CMD_READ_CONT = 8'h03;
	localparam logic [7:0] CMD_STOP_CONT = 8'h0f;
	localparam logic [7:0] CMD_REG_READ = 8'h10;
	localparam logic [7:0] CMD_REG_WRITE = 8'h50;
	localparam logic [7:0] CMD_SELF_OFFSET_CAL = 8'hf1;
	localparam logic [7:0] CMD_SELF_GAIN_CAL = 8'hf2;
	localparam logic [7:0] CMD_SELF_FULL_CAL = 8'hf0;
	localparam logic [7:0] CMD_SYS_OFFSET_CAL = 8'hf3;
	localparam logic [7:0] CMD_SYS_GAIN_CAL = 8'hf4;
	localparam logic [7:0] CMD_SYNC = 8'hfc;
	localparam logic [7:0] CMD_SLEEP = 8'hfd;
	localparam logic [7:0] CMD_RESET = 8'hfe;
	localparam logic [3:0] REG_MUX = 4'h1;
	localparam logic [7:0] MUX_RESET = 8'h08;
	localparam logic [3:0] CH_COMMON = 4'h8;
	localparam int NUM_CH_LARGE = 8;
	localparam int NUM_CH_SMALL = 4;
	localparam int RESULT_W = 24;
	// ==========================================
	// carriers
	typedef struct packed {
		logic [3:0] pos;
		logic [3:0] neg;
	} asct_mux_s;
	typedef struct packed {
		logic valid;
		logic [7:0] cmd;
		logic [7:0] arg;
	} asct_cmd_s;
endpackage

// *** design/asct_result_mem.sv ***
/*
 result holding register bank: eight words addressed by positive channel pos[2:0], registered read.
 assumes single clock, write and read in the system domain.
*/
`timescale 1ns/100ps
`default_nettype none
module asct_result_mem import asct_pkg::*; (
	input wire logic clk,
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [RESULT_W-1:0] wdata,
	input wire logic [2:0] raddr,
	output logic [RESULT_W-1:0] rdata
);
	logic [RESULT_W-1:0] mem [0:7];
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // asct_result_mem
`default_nettype wire

// *** verif/asct_top_props.sv ***
/*
 port timing checker for asct_top.
 assumes the host toggles sclk only inside frames.
*/
`timescale 1ns/100ps
`default_nettype none
module asct_top_props import asct_pkg::*; #(
	parameter int CONV_PERIOD_CYC = CONV_PERIOD_CYC_DEF,
	parameter bit LARGE_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic reset_pin_n,
	input wire logic [RESULT_W-1:0] modulator_result,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic conversion_ready_n,
	input wire asct_mux_s mux_sel
);
	// ==========================================
	// helpers
	localparam int REL_MIN = 236;
	localparam int REL_MAX = 404;
	localparam int GAP_MAX = 6 * CONV_PERIOD_CYC + 400;
	logic sclk_q;
	logic [31:0] idle;
	logic [31:0] gap;
	// sclk sampled in clk domain, so allow a few clk of sync skew
	always_ff @(posedge clk) begin
		sclk_q <= sclk;
		idle <= (reset || sclk != sclk_q) ? '0 : idle + 32'(idle != '1);
	end
	always_ff @(posedge clk) begin
		if (reset || !reset_pin_n || $fell(conversion_ready_n))
			gap <= '0;
		else
			gap <= gap + 32'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ==========================================
	// properties
	property p_reset_idle;
		disable iff (1'b0) reset |=> !dout_oe && conversion_ready_n && mux_sel == MUX_RESET;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("outputs busy in reset");
	property p_pin_reset;
		$fell(reset_pin_n) |-> ##[2:9] (conversion_ready_n && !dout_oe && mux_sel == MUX_RESET);
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored");
	property p_deselect;
		$rose(cs_n) |-> ##[1:4] !dout_oe;
	endproperty
	a_deselect: assert property (p_deselect) else $error("dout kept on deselect");
	property p_release_max;
		idle >= REL_MAX |-> !dout_oe;
	endproperty
	a_release_max: assert property (p_release_max) else $error("dout released late");
	property p_release_min;
		$fell(dout_oe) && !cs_n && reset_pin_n |-> idle >= REL_MIN;
	endproperty
	a_release_min: assert property (p_release_min) else $error("dout released early");
	property p_invalid_gap;
		$fell(conversion_ready_n) |-> gap > DOR_INVALID_CYC;
	endproperty
	a_invalid_gap: assert property (p_invalid_gap) else $error("ready fell too soon");
	property p_ready_due;
		gap < GAP_MAX;
	endproperty
	a_ready_due: assert property (p_ready_due) else $error("ready never fell");
	property p_mux_settle;
		$changed(mux_sel) |-> ##[1:1000] $fell(conversion_ready_n);
	endproperty
	a_mux_settle: assert property (p_mux_settle) else $error("no data after mux change");
	c_deselect: cover property ($rose(cs_n) ##[1:4] !dout_oe);
	c_mux: cover property ($changed(mux_sel));
	c_ready: cover property ($fell(conversion_ready_n));
endmodule // asct_top_props
bind asct_top asct_top_props #(.CONV_PERIOD_CYC(CONV_PERIOD_CYC), .LARGE_VARIANT(LARGE_VARIANT))
	u_asct_top_props (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din),
	.reset_pin_n(reset_pin_n), .modulator_result(modulator_result), .dout(dout),
	.dout_oe(dout_oe), .conversion_ready_n(conversion_ready_n), .mux_sel(mux_sel));
`default_nettype wire

// *** verif/asct_host_model.sv ***
/*
 serial host model: mode 0 master on a 32 ns link clock.
 assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module asct_host_model import asct_pkg::*; (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	localparam int HALF_NS = 16;
	logic tie_select = 1'b0;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b1;
	end
	task automatic osc_wait(input int n);
		#(n * OSC_PERIOD_NS);
	endtask
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			din = b[i];
			#HALF_NS sclk = 1'b1;
			#HALF_NS sclk = 1'b0;
		end
		// line left changing so a stale bit is never mistaken for data
		din = ~b[0];
	endtask
	task automatic command(input logic [23:0] bytes, input int n);
		if (!tie_select)
			cs_n = 1'b0;
		for (int k = n - 1; k >= 0; k--)
			send_byte(bytes[8*k +: 8]);
		if (n > 1)
			osc_wait(8);
		if (!tie_select)
			cs_n = 1'b1;
		osc_wait(4);
	endtask
	// leaves the frame open so the caller can look at dout_oe
	task automatic read_result(output logic [23:0] w);
		cs_n = 1'b0;
		send_byte(CMD_READ_RESULT);
		osc_wait(50);
		for (int i = 23; i >= 0; i--) begin
			#HALF_NS sclk = 1'b1;
			// first high phase stretched: output re-enables only after edge sync
			#(HALF_NS - 1 + ((i == 23) ? 48 : 0)) w[i] = dout_oe ? dout : 1'bx;
			#1 sclk = 1'b0;
		end
	endtask
	task automatic end_frame;
		cs_n = 1'b1;
		osc_wait(4);
	endtask
endmodule // asct_host_model
`default_nettype wire

// *** verif/adc_serial_command_timing_tb.sv ***
/*
 self-checking bench for asct_top with a host model.
 assumes a short conversion period for run time.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module adc_serial_command_timing_tb import asct_pkg::*;;
	localparam int CONV = 200;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic reset_pin_n = 1'b1;
	logic [RESULT_W-1:0] modulator_result = '0;
	logic sclk, cs_n, din, dout, dout_oe, conversion_ready_n;
	asct_mux_s mux_sel;
	int err_count = 0;
	int cmp_count = 0;
	always #5 clk = ~clk;
	asct_top #(.CONV_PERIOD_CYC(CONV)) u_asct_top (.clk(clk), .reset(reset), .sclk(sclk),
		.cs_n(cs_n), .din(din), .reset_pin_n(reset_pin_n), .modulator_result(modulator_result),
		.dout(dout), .dout_oe(dout_oe), .conversion_ready_n(conversion_ready_n),
		.mux_sel(mux_sel));
	asct_host_model u_asct_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe(dout_oe));
	task automatic final_report;
		$display("errors %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// waits for a fresh falling edge of ready, returns cycles spent
	task automatic wait_fall(output int n);
		n = 0;
		while (conversion_ready_n !== 1'b1 && n < 8 * CONV) begin @(posedge clk); n++; end
		while (conversion_ready_n !== 1'b0 && n < 8 * CONV) begin @(posedge clk); n++; end
		`CHK(conversion_ready_n, 1'b0)
	endtask
	task automatic t_read;
		logic [23:0] w;
		int n;
		wait_fall(n);
		u_asct_host_model.read_result(w);
		`CHK(w, 24'h5a3c96)
		`CHK(dout_oe, 1'b1)
		u_asct_host_model.end_frame();
		`CHK(dout_oe, 1'b0)
	endtask
	task automatic t_mux;
		logic [7:0] pairs [5] = '{8'h01, 8'h78, 8'h83, 8'h50, 8'h26};
		int n;
		u_asct_host_model.cs_n = 1'b0;
		u_asct_host_model.tie_select = 1'b1;
		foreach (pairs[i]) begin
			wait_fall(n);
			u_asct_host_model.command({CMD_REG_WRITE | 8'(REG_MUX), 8'h00, pairs[i]}, 3);
			`CHK(mux_sel, pairs[i])
			u_asct_host_model.osc_wait(11);
			`CHK(dout_oe, 1'b0)
		end
		u_asct_host_model.tie_select = 1'b0;
		u_asct_host_model.cs_n = 1'b1;
	endtask
	task automatic t_cal;
		logic [7:0] cmds [5] = '{CMD_SELF_OFFSET_CAL, CMD_SELF_GAIN_CAL, CMD_SYS_OFFSET_CAL,
			CMD_SYS_GAIN_CAL, CMD_SELF_FULL_CAL};
		int lo, n;
		foreach (cmds[i]) begin
			lo = (i == 4) ? FULL_CAL_CONV_PERIODS : CAL_CONV_PERIODS;
			wait_fall(n);
			u_asct_host_model.command({16'h0000, cmds[i]}, 1);
			wait_fall(n);
			`CHK(n inside {[(lo - 1) * CONV + DOR_INVALID_CYC:(lo + 1) * CONV + 200]}, 1'b1)
		end
	endtask
	task automatic t_cont;
		int n;
		u_asct_host_model.command({16'h0000, CMD_READ_CONT}, 1);
		wait_fall(n);
		u_asct_host_model.osc_wait(10);
		u_asct_host_model.command({16'h0000, CMD_STOP_CONT}, 1);
		wait_fall(n);
		`CHK(n < 2 * CONV, 1'b1)
	endtask
	task automatic t_pin;
		@(posedge clk);
		reset_pin_n <= 1'b0;
		repeat (10) @(posedge clk);
		`CHK(mux_sel, MUX_RESET)
		`CHK(conversion_ready_n, 1'b1)
		reset_pin_n <= 1'b1;
		u_asct_host_model.osc_wait(16);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		modulator_result <= 24'h5a3c96;
		@(posedge clk);
		`CHK(mux_sel, MUX_RESET)
		`CHK(dout_oe, 1'b0)
		u_asct_host_model.osc_wait(16);
		t_read();
		t_cont();
		t_mux();
		t_cal();
		t_pin();
		final_report();
	end
	initial begin
		#400000;
		err_count++;
		final_report();
	end
endmodule // adc_serial_command_timing_tb
`default_nettype wire
